/* alsd_top.sv */
/*
  Ambient light dimming control: I2C register slave, sensor polling, gain trim,
  level lookup, secondary group threshold response and PWM bypass.
  Assumes the sample source runs on clk_in; SCL, SDA and the PWM pin are asynchronous.
*/
// Function
// - Bypass bit 0 passes external PWM; 1 forces fixed 97.5% duty.
// - Polling mode bit 0 polls automatically; 1 polls only on manual request.
// - Auto poll interval field: 0.5 s, 1.0 s, 1.5 s, 2.0 s.
// - Gain trim codes 0000..0111 add 0% to +43.75% in 6.25% steps.
// - Gain trim codes 1000..1111 apply -50% up to -6.25% in 6.25% steps.
// - Trimmed sensor result readable at 0x11, read only, resets to zero.
// - Sixteen 7-bit dimming level registers at 0x12 through 0x21.
// - Level code drives LED sink current, 0.90 mA up to 27.9 mA.
// - Secondary high threshold held in threshold register bits 7..4.
// - Secondary low threshold held in threshold register bits 3..0.
// - Direction bit: 0 dimming response, 1 brightening response.
// - Secondary group reacts to readings only while its enable bit is 1.
// - Measurement and sensor dimming run only while sensor enable is 1.
`timescale 1ns/1ps
module alsd_top #(
  parameter int         POLL_STEP_CYC = alsd_pkg::POLL_STEP_CYC,
  parameter logic [6:0] I2C_DEV_ADDR  = 7'h3C  // Arbitrary slave address
) (
  input  wire logic       clk_in,
  input  wire logic       rst_in,
  input  wire logic       scl_in,
  input  wire logic       sda_in,
  output logic            sda_out,
  output logic            sda_oe_n_out,
  input  wire logic       pwm_in,
  input  wire logic       manual_poll_in,
  input  wire logic       sample_valid_in,
  input  wire logic [7:0] sample_data_in,
  output logic            sample_req_out,
  output logic [6:0]      main_level_out,
  output logic            pwm_dim_out,
  output logic            sub_adjust_out,
  output logic            sub_direction_out
);

  // Input synchronisers; stage one feeds stage two only
  logic [1:0] scl_sy_q, sda_sy_q, pwm_sy_q;
  logic       scl_p_q, sda_p_q;
  always_ff @(posedge clk_in) begin
    scl_sy_q <= {scl_sy_q[0], scl_in};
    sda_sy_q <= {sda_sy_q[0], sda_in};
    pwm_sy_q <= {pwm_sy_q[0], pwm_in};
    scl_p_q  <= scl_sy_q[1];
    sda_p_q  <= sda_sy_q[1];
  end
  logic scl_s, sda_s, scl_rise, scl_fall, i2c_start, i2c_stop;
  assign scl_s     = scl_sy_q[1];
  assign sda_s     = sda_sy_q[1];
  assign scl_rise  = scl_s & ~scl_p_q;
  assign scl_fall  = ~scl_s & scl_p_q;
  assign i2c_start = scl_s & scl_p_q & sda_p_q & ~sda_s;
  assign i2c_stop  = scl_s & scl_p_q & ~sda_p_q & sda_s;

  // Register file state
  alsd_pkg::alsd_cfg_t  cfg_q, cfg_d;
  alsd_pkg::alsd_thr_t  thr_q, thr_d;
  alsd_pkg::alsd_subc_t subc_q, subc_d;
  logic                 sen_q, sen_d;
  logic [6:0]           lvl_q [16];
  logic [6:0]           lvl_d [16];
  logic [7:0]           result_q;

  // I2C slave; the first SCL fall after a START ends the START and is not a bit boundary
  alsd_pkg::alsd_i2c_st_t st_q, st_d;
  logic       skip_q, skip_d;
  logic [3:0] cnt_q, cnt_d;
  logic [7:0] sh_q, sh_d, tx_q, tx_d, ptr_q, ptr_d;
  logic       ack_q, ack_d, rw_q, rw_d, nack_q, nack_d;
  logic       wr_en;
  logic [7:0] rd_data;

  // Only the result register reads back; write-only registers answer zero
  assign rd_data = (ptr_q == alsd_pkg::ADDR_RESULT) ? result_q : 8'h00;

  always_comb begin
    st_d   = st_q;
    cnt_d  = cnt_q;
    sh_d   = sh_q;
    tx_d   = tx_q;
    ptr_d  = ptr_q;
    ack_d  = ack_q;
    rw_d   = rw_q;
    nack_d = nack_q;
    skip_d = skip_q;
    wr_en  = 1'b0;
    if (i2c_start) begin
      st_d   = alsd_pkg::ST_ADDR;
      cnt_d  = 4'h0;
      ack_d  = 1'b0;
      skip_d = 1'b1;
    end else if (i2c_stop) begin
      st_d  = alsd_pkg::ST_IDLE;
      ack_d = 1'b0;
    end else if (st_q != alsd_pkg::ST_IDLE) begin
      if (scl_rise && cnt_q < 4'h8)
        sh_d = {sh_q[6:0], sda_s};
      if (scl_rise && cnt_q == 4'h8)
        nack_d = sda_s;
      if (scl_fall && skip_q)
        skip_d = 1'b0;
      if (scl_fall && !skip_q) begin
        if (cnt_q < 4'h7) begin
          cnt_d = cnt_q + 4'h1;
          tx_d  = {tx_q[6:0], 1'b1};
        end else if (cnt_q == 4'h7) begin
          cnt_d = 4'h8;
          tx_d  = 8'hFF;
          case (st_q)
            alsd_pkg::ST_ADDR: begin
              if (sh_q[7:1] == I2C_DEV_ADDR) begin
                ack_d = 1'b1;
                rw_d  = sh_q[0];
              end else begin
                st_d = alsd_pkg::ST_IDLE;
              end
            end
            alsd_pkg::ST_REG: begin
              ack_d = 1'b1;
              ptr_d = sh_q;
            end
            alsd_pkg::ST_WDAT: begin
              ack_d = 1'b1;
              wr_en = 1'b1;
              ptr_d = ptr_q + 8'h01;
            end
            default: ;
          endcase
        end else begin
          cnt_d = 4'h0;
          ack_d = 1'b0;
          case (st_q)
            alsd_pkg::ST_ADDR: begin
              if (rw_q) begin
                st_d  = alsd_pkg::ST_RDAT;
                tx_d  = rd_data;
                ptr_d = ptr_q + 8'h01;
              end else begin
                st_d = alsd_pkg::ST_REG;
              end
            end
            alsd_pkg::ST_REG:  st_d = alsd_pkg::ST_WDAT;
            alsd_pkg::ST_WDAT: st_d = alsd_pkg::ST_WDAT;
            alsd_pkg::ST_RDAT: begin
              if (nack_q) begin
                st_d = alsd_pkg::ST_IDLE;
              end else begin
                tx_d  = rd_data;
                ptr_d = ptr_q + 8'h01;
              end
            end
            default: st_d = alsd_pkg::ST_IDLE;
          endcase
        end
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      st_q   <= alsd_pkg::ST_IDLE;
      skip_q <= 1'b0;
      cnt_q  <= 4'h0;
      sh_q   <= 8'h00;
      tx_q   <= 8'hFF;
      ptr_q  <= 8'h00;
      ack_q  <= 1'b0;
      rw_q   <= 1'b0;
      nack_q <= 1'b0;
    end else begin
      st_q   <= st_d;
      cnt_q  <= cnt_d;
      sh_q   <= sh_d;
      tx_q   <= tx_d;
      ptr_q  <= ptr_d;
      ack_q  <= ack_d;
      rw_q   <= rw_d;
      nack_q <= nack_d;
      skip_q <= skip_d;
    end
  end

  // Open drain: only ever pull low, enable active low
  assign sda_out      = 1'b0;
  assign sda_oe_n_out = ~(ack_q | (st_q == alsd_pkg::ST_RDAT && cnt_q < 4'h8 && !tx_q[7]));

  // Register writes
  logic [7:0] lvl_idx;
  assign lvl_idx = ptr_q - alsd_pkg::ADDR_LVL_FIRST;
  always_comb begin
    cfg_d  = cfg_q;
    thr_d  = thr_q;
    subc_d = subc_q;
    sen_d  = sen_q;
    lvl_d  = lvl_q;
    if (wr_en) begin
      case (ptr_q)
        alsd_pkg::ADDR_SENSOR_EN: sen_d = sh_q[alsd_pkg::SENSOR_EN_BIT];
        alsd_pkg::ADDR_CFG:       cfg_d = sh_q;
        alsd_pkg::ADDR_THR:       thr_d = sh_q;
        alsd_pkg::ADDR_SUBC:      subc_d = sh_q[1:0];
        default: begin
          if (ptr_q >= alsd_pkg::ADDR_LVL_FIRST && ptr_q <= alsd_pkg::ADDR_LVL_LAST)
            lvl_d[lvl_idx[3:0]] = sh_q[alsd_pkg::LVL_TOP_BIT:0];
        end
      endcase
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      cfg_q  <= alsd_pkg::RST_CFG;
      thr_q  <= alsd_pkg::RST_THR;
      subc_q <= alsd_pkg::RST_SUBC;
      sen_q  <= 1'b0;
      for (int i = 0; i < 16; i++) lvl_q[i] <= alsd_pkg::RST_LVL;
    end else begin
      cfg_q  <= cfg_d;
      thr_q  <= thr_d;
      subc_q <= subc_d;
      sen_q  <= sen_d;
      lvl_q  <= lvl_d;
    end
  end

  // Sensing, lookup and dimming
  logic [31:0] tmr_q, tmr_d, interval;
  logic        req_q, req_d, pwm_q, pwm_d, sub_act_q, sub_act_d, sub_out_q, sub_out_d;
  logic [7:0]  result_d;
  logic [6:0]  main_q, main_d;
  logic [5:0]  pcnt_q, pcnt_d;
  logic [4:0]  factor;
  logic [12:0] prod;
  logic [7:0]  scaled;
  logic [3:0]  range;

  assign interval = 32'(POLL_STEP_CYC) * {30'h0, cfg_q.poll_interval} + 32'(POLL_STEP_CYC);
  // Sixteenths: 16 + signed trim, so 1000 gives 8/16 and 0111 gives 23/16
  assign factor = {~cfg_q.input_gain_trim[3], cfg_q.input_gain_trim};
  assign prod   = sample_data_in * factor;
  assign scaled = prod[12] ? 8'hFF : prod[11:4];
  assign range  = result_q[7:4];

  always_comb begin
    tmr_d     = tmr_q;
    req_d     = 1'b0;
    result_d  = result_q;
    main_d    = 7'h00;
    sub_act_d = 1'b0;
    sub_out_d = 1'b0;
    pcnt_d    = (pcnt_q == 6'(alsd_pkg::PWM_PERIOD_CYC - 1)) ? 6'h00 : pcnt_q + 6'h01;
    pwm_d     = cfg_q.pwm_input_bypass ? (pcnt_q < 6'(alsd_pkg::PWM_HIGH_CYC)) : pwm_sy_q[1];
    if (sen_q) begin
      if (cfg_q.poll_manual_select) begin
        tmr_d = 32'h0000_0000;
        req_d = manual_poll_in;
      end else if (tmr_q >= interval - 32'h0000_0001) begin
        tmr_d = 32'h0000_0000;
        req_d = 1'b1;
      end else begin
        tmr_d = tmr_q + 32'h0000_0001;
      end
      if (sample_valid_in)
        result_d = scaled;
      main_d    = lvl_q[range];
      // Hysteresis between low and high thresholds
      sub_act_d = sub_act_q;
      if (range > thr_q.high)
        sub_act_d = 1'b1;
      else if (range < thr_q.low)
        sub_act_d = 1'b0;
      sub_out_d = sub_act_d & subc_q.enable;
    end else begin
      tmr_d = 32'h0000_0000;
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      tmr_q     <= 32'h0000_0000;
      req_q     <= 1'b0;
      result_q  <= alsd_pkg::RST_RESULT;
      main_q    <= 7'h00;
      sub_act_q <= 1'b0;
      sub_out_q <= 1'b0;
      pcnt_q    <= 6'h00;
      pwm_q     <= 1'b0;
    end else begin
      tmr_q     <= tmr_d;
      req_q     <= req_d;
      result_q  <= result_d;
      main_q    <= main_d;
      sub_act_q <= sub_act_d;
      sub_out_q <= sub_out_d;
      pcnt_q    <= pcnt_d;
      pwm_q     <= pwm_d;
    end
  end

  assign sample_req_out    = req_q;
  assign main_level_out    = main_q;
  assign pwm_dim_out       = pwm_q;
  assign sub_adjust_out    = sub_out_q;
  assign sub_direction_out = subc_q.secondary_group_direction;

  pwm_pass_a: assert property (@(posedge clk_in) disable iff (rst_in)
    !cfg_q.pwm_input_bypass |=> pwm_q == $past(pwm_sy_q[1])) else $error("PWM input not passed");
  pwm_bypass_a: assert property (@(posedge clk_in) disable iff (rst_in)
    cfg_q.pwm_input_bypass && pcnt_q == 6'd39 |=> !pwm_q) else $error("Bypass duty not 39 of 40");
  manual_poll_a: assert property (@(posedge clk_in) disable iff (rst_in)
    sen_q && cfg_q.poll_manual_select |=> req_q == $past(manual_poll_in)) else $error("Manual poll mismatch");
  poll_interval_a: assert property (@(posedge clk_in) disable iff (rst_in)
    req_q && !$past(cfg_q.poll_manual_select) && $stable(cfg_q) && sen_q && !cfg_q.poll_manual_select
    |=> !req_q && tmr_q == 32'd1) else $error("Poll timer did not restart");
  gain_zero_a: assert property (@(posedge clk_in) disable iff (rst_in)
    sen_q && sample_valid_in && cfg_q.input_gain_trim == 4'h0 |=> result_q == $past(sample_data_in))
    else $error("Zero trim changed reading");
  gain_half_a: assert property (@(posedge clk_in) disable iff (rst_in)
    sen_q && sample_valid_in && cfg_q.input_gain_trim == 4'h8 |=> result_q == ($past(sample_data_in) >> 1))
    else $error("Trim 1000 is not minus half");
  result_hold_a: assert property (@(posedge clk_in) disable iff (rst_in)
    !sample_valid_in |=> $stable(result_q)) else $error("Result changed without sample");
  level_lookup_a: assert property (@(posedge clk_in) disable iff (rst_in)
    sen_q && !wr_en |=> main_q == lvl_q[$past(result_q[7:4])]) else $error("Wrong dimming level");
  sub_enable_a: assert property (@(posedge clk_in) disable iff (rst_in)
    !subc_q.enable |=> !sub_out_q) else $error("Secondary reacted while disabled");
  sub_high_a: assert property (@(posedge clk_in) disable iff (rst_in)
    sen_q && subc_q.enable && result_q[7:4] > thr_q.high |=> sub_out_q) else $error("High threshold missed");
  sub_low_a: assert property (@(posedge clk_in) disable iff (rst_in)
    sen_q && result_q[7:4] < thr_q.low && result_q[7:4] <= thr_q.high |=> !sub_out_q)
    else $error("Low threshold missed");
  sensor_off_a: assert property (@(posedge clk_in) disable iff (rst_in)
    !sen_q |=> !req_q && main_q == 7'h00 && !sub_out_q) else $error("Sensing while disabled");

endmodule // alsd_top

/* alsd_pkg.sv */
/*
  Constants, register map and carrier types for the ambient light dimming control.
  Assumes one 200 MHz system clock; all users reference names as alsd_pkg::name.
*/
package alsd_pkg;

  // Register offsets
  localparam logic [7:0] ADDR_SENSOR_EN = 8'h0E;
  localparam logic [7:0] ADDR_CFG       = 8'h10;
  localparam logic [7:0] ADDR_RESULT    = 8'h11;
  localparam logic [7:0] ADDR_LVL_FIRST = 8'h12;
  localparam logic [7:0] ADDR_LVL_LAST  = 8'h21;
  localparam logic [7:0] ADDR_THR       = 8'h22;
  localparam logic [7:0] ADDR_SUBC      = 8'h23;

  // Field positions not carried by a struct
  localparam int SENSOR_EN_BIT = 0;
  localparam int LVL_TOP_BIT   = 6;

  // Reset values
  localparam logic [7:0] RST_CFG    = 8'h00;
  localparam logic [7:0] RST_RESULT = 8'h00;
  localparam logic [6:0] RST_LVL    = 7'h00;
  localparam logic [7:0] RST_THR    = 8'h00;
  localparam logic [1:0] RST_SUBC   = 2'h0;

  // Timing
  localparam int CLK_MHZ        = 200;
  localparam int POLL_STEP_MS   = 500;
  localparam int POLL_STEP_CYC  = POLL_STEP_MS * 1000 * CLK_MHZ;
  localparam int PWM_PERIOD_CYC = 40;
  localparam int PWM_DUTY_PERMIL = 975;
  localparam int PWM_HIGH_CYC   = PWM_PERIOD_CYC * PWM_DUTY_PERMIL / 1000;

  typedef struct packed {
    logic       pwm_input_bypass;
    logic       poll_manual_select;
    logic [1:0] poll_interval;
    logic [3:0] input_gain_trim;
  } alsd_cfg_t;

  typedef struct packed {
    logic [3:0] high;
    logic [3:0] low;
  } alsd_thr_t;

  typedef struct packed {
    logic secondary_group_direction;
    logic enable;
  } alsd_subc_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_ADDR = 3'h1,
    ST_REG  = 3'h3,
    ST_WDAT = 3'h2,
    ST_RDAT = 3'h6
  } alsd_i2c_st_t;

endpackage

/* alsd_i2c_host.sv */
/*
  I2C master model standing in for the host on the register port.
  Assumes the bench resolves SDA as open drain with a pull-up.
*/
`timescale 1ns/1ps
module alsd_i2c_host #(
  parameter int         HALF = 8,
  parameter logic [6:0] DEV  = 7'h3C
) (
  input  wire logic clk_in,
  input  wire logic sda_in,
  output logic      scl_out,
  output logic      sda_out,
  output int        nack_out
);
  initial begin
    scl_out  = 1'b1;
    sda_out  = 1'b1;
    nack_out = 0;
  end

  task automatic step(input logic c, input logic d);
    scl_out <= c;
    sda_out <= d;
    repeat (HALF) @(posedge clk_in);
  endtask

  task automatic start();
    step(1'b0, sda_out);
    step(1'b0, 1'b1);
    step(1'b1, 1'b1);
    step(1'b1, 1'b0);
  endtask

  task automatic stop();
    step(1'b0, sda_out);
    step(1'b0, 1'b0);
    step(1'b1, 1'b0);
    step(1'b1, 1'b1);
  endtask

  // SDA only moves while SCL is low, so no false START or STOP is seen
  task automatic xfer(input logic [8:0] d, input logic chk, output logic [7:0] q);
    logic [8:0] s;
    for (int i = 8; i >= 0; i--) begin
      step(1'b0, sda_out);
      step(1'b0, d[i]);
      step(1'b1, d[i]);
      s[i] = sda_in;
    end
    q = s[8:1];
    if (chk && s[0]) nack_out++;
  endtask

  task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] q;
    start();
    xfer({DEV, 2'b01}, 1'b1, q);
    xfer({a, 1'b1}, 1'b1, q);
    xfer({d, 1'b1}, 1'b1, q);
    stop();
  endtask

  task automatic read_reg(input logic [7:0] a, output logic [7:0] q);
    logic [7:0] x;
    start();
    xfer({DEV, 2'b01}, 1'b1, x);
    xfer({a, 1'b1}, 1'b1, x);
    start();
    xfer({DEV, 2'b11}, 1'b1, x);
    xfer(9'h1FF, 1'b0, q);
    stop();
  endtask
endmodule // alsd_i2c_host

/* ambient_light_dimming_ctrl_tb.sv */
/*
  Self-checking bench for alsd_top, registers reached over I2C.
  Assumes alsd_pkg and the host model are compiled first.
*/
`timescale 1ns/1ps
`define CHK(a, e) begin checks_done++; if ((a) !== (e)) begin error_cnt++; $display("Error %0t got %h want %h", $time, a, e); end end
module ambient_light_dimming_ctrl_tb;
  localparam int STEP = 20;
  logic       clk_in = 1'b0;
  logic       rst_in = 1'b1;
  logic       pwm_in, manual_poll_in, sample_valid_in;
  logic [7:0] sample_data_in;
  logic       sda_out, sda_oe_n_out, sample_req_out, pwm_dim_out;
  logic       sub_adjust_out, sub_direction_out, scl, h_sda;
  logic [6:0] main_level_out;
  logic [6:0] lv [16];
  logic [7:0] r, d, e;
  logic [7:0] sv [5] = '{8'h20, 8'h80, 8'h90, 8'h30, 8'h20};
  logic       sx [5] = '{1'b0, 1'b0, 1'b1, 1'b1, 1'b0};
  int         error_cnt = 0, checks_done = 0, seed = 13720, nacks, n, g;
  wire        sda_w = h_sda & (sda_oe_n_out | sda_out);

  always #2.5 clk_in = ~clk_in;

  alsd_top #(.POLL_STEP_CYC(STEP)) uut (.clk_in(clk_in), .rst_in(rst_in), .scl_in(scl),
    .sda_in(sda_w), .sda_out(sda_out), .sda_oe_n_out(sda_oe_n_out), .pwm_in(pwm_in),
    .manual_poll_in(manual_poll_in), .sample_valid_in(sample_valid_in),
    .sample_data_in(sample_data_in), .sample_req_out(sample_req_out),
    .main_level_out(main_level_out), .pwm_dim_out(pwm_dim_out),
    .sub_adjust_out(sub_adjust_out), .sub_direction_out(sub_direction_out));

  alsd_i2c_host host (.clk_in(clk_in), .sda_in(sda_w), .scl_out(scl), .sda_out(h_sda),
    .nack_out(nacks));

  function automatic logic [7:0] exp_res(input logic [7:0] x, input logic [3:0] t);
    int p;
    p = int'(x) * (16 + (t[3] ? int'(t) - 16 : int'(t))) / 16;
    return (p > 255) ? 8'hFF : p[7:0];
  endfunction

  task automatic smp(input logic [7:0] x);
    sample_valid_in <= 1'b1;
    sample_data_in  <= x;
    @(posedge clk_in);
    sample_valid_in <= 1'b0;
    repeat (4) @(posedge clk_in);
  endtask

  // Gap ends as the spacing of the last two request pulses seen
  task automatic reqs(input int len, output int c, output int gap);
    int last;
    c = 0;
    gap = 0;
    last = 0;
    for (int i = 0; i < len; i++) begin
      @(posedge clk_in);
      if (sample_req_out === 1'b1) begin
        gap = i - last;
        last = i;
        c++;
      end
    end
  endtask

  task automatic complete_run();
    $display("checks %0d errors %0d nacks %0d", checks_done, error_cnt, nacks);
    if (error_cnt == 0 && nacks == 0 && checks_done > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  initial begin
    repeat (90000) @(posedge clk_in);
    error_cnt++;
    complete_run();
  end

  initial begin
    pwm_in = 1'b0;
    manual_poll_in = 1'b0;
    sample_valid_in = 1'b0;
    sample_data_in = 8'h00;
    repeat (16) @(posedge clk_in);
    rst_in <= 1'b0;
    repeat (4) @(posedge clk_in);
    `CHK(main_level_out, 7'h00)
    host.read_reg(alsd_pkg::ADDR_RESULT, r);
    `CHK(r, alsd_pkg::RST_RESULT)
    host.write_reg(alsd_pkg::ADDR_SENSOR_EN, 8'h01);
    for (int i = 0; i < 16; i++) begin
      lv[i] = 7'($random(seed));
      host.write_reg(alsd_pkg::ADDR_LVL_FIRST + 8'(i), {1'b1, lv[i]});
    end
    host.read_reg(alsd_pkg::ADDR_LVL_FIRST, r);
    `CHK(r, 8'h00)
    $display("test levels done");
    for (int t = 0; t < 16; t++) begin
      host.write_reg(alsd_pkg::ADDR_CFG, {4'h4, 4'(t)});
      d = (t == 7) ? 8'hFF : 8'($random(seed));
      e = exp_res(d, 4'(t));
      smp(d);
      `CHK(main_level_out, lv[e[7:4]])
      host.read_reg(alsd_pkg::ADDR_RESULT, r);
      `CHK(r, e)
    end
    host.write_reg(alsd_pkg::ADDR_RESULT, 8'h5A);
    host.read_reg(alsd_pkg::ADDR_RESULT, r);
    `CHK(r, e)
    $display("test gain done");
    reqs(200, n, g);
    `CHK(n, 0)
    manual_poll_in <= 1'b1;
    @(posedge clk_in);
    manual_poll_in <= 1'b0;
    reqs(10, n, g);
    `CHK(n, 1)
    for (int iv = 0; iv < 4; iv++) begin
      host.write_reg(alsd_pkg::ADDR_CFG, {2'b00, 2'(iv), 4'h0});
      reqs(STEP * 13, n, g);
      `CHK(g, STEP * (iv + 1))
    end
    $display("test polling done");
    host.write_reg(alsd_pkg::ADDR_CFG, 8'h40);
    pwm_in <= 1'b1;
    repeat (8) @(posedge clk_in);
    `CHK(pwm_dim_out, 1'b1)
    pwm_in <= 1'b0;
    repeat (8) @(posedge clk_in);
    `CHK(pwm_dim_out, 1'b0)
    host.write_reg(alsd_pkg::ADDR_CFG, 8'hC0);
    n = 0;
    for (int i = 0; i < 80; i++) begin
      @(posedge clk_in);
      n += int'(pwm_dim_out === 1'b1);
    end
    `CHK(n, 78)
    $display("test pwm done");
    host.write_reg(alsd_pkg::ADDR_CFG, 8'h40);
    host.write_reg(alsd_pkg::ADDR_THR, 8'h83);
    host.write_reg(alsd_pkg::ADDR_SUBC, 8'h03);
    // Readings sit on both threshold edges, where the state must hold
    for (int i = 0; i < 5; i++) begin
      smp(sv[i]);
      `CHK(sub_adjust_out, sx[i])
      `CHK(sub_direction_out, 1'b1)
    end
    host.write_reg(alsd_pkg::ADDR_SUBC, 8'h01);
    smp(8'h90);
    `CHK(sub_adjust_out, 1'b1)
    `CHK(sub_direction_out, 1'b0)
    host.write_reg(alsd_pkg::ADDR_SUBC, 8'h02);
    smp(8'h90);
    `CHK(sub_adjust_out, 1'b0)
    $display("test secondary done");
    host.write_reg(alsd_pkg::ADDR_SENSOR_EN, 8'h00);
    smp(8'h77);
    `CHK(main_level_out, 7'h00)
    host.read_reg(alsd_pkg::ADDR_RESULT, r);
    `CHK(r, 8'h90)
    $display("test disable done");
    complete_run();
  end
endmodule // ambient_light_dimming_ctrl_tb
